//--- logic/acr_pkg.sv
/*
  Constants shared by the serial configuration register bank: register
  offsets, field positions, reset value, power-state codes and timing.
  Assumes a single 250 MHz core clock.
*/
package acr_pkg;
  localparam int NREG = 19;
  localparam int IDXW = 5;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] REG_OFS [NREG] = '{
    8'h00, 8'h20, 8'h3F, 8'h40, 8'h41, 8'h44, 8'h50, 8'h51, 8'h52, 8'h53,
    8'h55, 8'h57, 8'h62, 8'h63, 8'h66, 8'h68, 8'h6A, 8'h75, 8'h76};
  // entry numbers of the registers whose fields steer this block
  localparam int IDX_RESET = 0;
  localparam int IDX_LOWRATE = 1;
  localparam int IDX_REFSTBY = 2;
  localparam int IDX_PSTATE = 3;
  localparam int IDX_OUTIF = 4;
  localparam int NCTL = 5;
  // field positions
  localparam int SRST_BIT = 7;
  localparam int READOUT_BIT = 0;
  localparam int LOWRATE_BIT = 2;
  localparam int REF_HI = 6;
  localparam int REF_LO = 5;
  localparam int STBY_BIT = 1;
  localparam int PSTATE_HI = 3;
  localparam int OUTIF_LVDS_BIT = 7;
  localparam logic [1:0] REF_EXT = 2'h3;
  // power-state codes
  localparam logic [3:0] PS_STRAP = 4'h0;
  localparam logic [3:0] PS_NORMAL = 4'h8;
  localparam logic [3:0] PS_BUF_B_OFF = 4'h9;
  localparam logic [3:0] PS_BUF_A_OFF = 4'hA;
  localparam logic [3:0] PS_BUF_AB_OFF = 4'hB;
  localparam logic [3:0] PS_GLOBAL_PD = 4'hC;
  localparam logic [3:0] PS_STBY_B = 4'hD;
  localparam logic [3:0] PS_STBY_A = 4'hE;
  localparam logic [3:0] PS_MUX = 4'hF;
  // strap codes, pin one in the top bit
  localparam logic [2:0] ST_GLOBAL_PD = 3'h4;
  localparam logic [2:0] ST_STBY_B = 3'h5;
  localparam logic [2:0] ST_STBY_A = 3'h6;
  localparam logic [2:0] ST_MUX = 3'h7;
  // serial word
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [3:0] WORD_LAST = 4'hF;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_PULSE_NS = 10;
  // samples a pulse just over the minimum is sure to show
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000) / CLK_PERIOD_PS;

  // entry number of an address, NREG when unmapped
  function automatic logic [IDXW-1:0] reg_index(input logic [7:0] addr);
    logic [IDXW-1:0] idx;
    idx = IDXW'(NREG);
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFS[i] == addr) begin
        idx = IDXW'(i);
      end
    end
    return idx;
  endfunction
endpackage

//--- logic/acr_regs_if.sv
/*
  Carrier between the serial front end and the register store.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface acr_regs_if;
  logic we;
  logic clr;
  logic [acr_pkg::IDXW-1:0] widx;
  logic [7:0] wdata;
  logic [acr_pkg::IDXW-1:0] ridx;
  logic [7:0] rdata;
  logic [acr_pkg::NCTL-1:0][7:0] ctl;
  modport ctrl (output we, clr, widx, wdata, ridx, input rdata, ctl);
  modport store (input we, clr, widx, wdata, ridx, output rdata, ctl);
endinterface

//--- logic/acr_reg_store.sv
/*
  Register store: one byte per mapped register, cleared together,
  registered read port, and the control registers exposed directly.
  Assumes the index of an unmapped address equals NREG.
*/
`timescale 1ns/1ps
module acr_reg_store (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // access
  acr_regs_if.store rif
);
  logic [7:0] mem_r [acr_pkg::NREG];

  for (genvar i = 0; i < acr_pkg::NREG; i++) begin : g_ent
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        mem_r[i] <= acr_pkg::RESET_VAL;
      end else if (rif.clr) begin
        mem_r[i] <= acr_pkg::RESET_VAL;
      end else if (rif.we && rif.widx == acr_pkg::IDXW'(i)) begin
        mem_r[i] <= rif.wdata;
      end
    end
  end

  for (genvar k = 0; k < acr_pkg::NCTL; k++) begin : g_ctl
    assign rif.ctl[k] = mem_r[k];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rif.rdata <= 8'h00;
    end else if (rif.ridx < acr_pkg::IDXW'(acr_pkg::NREG)) begin
      rif.rdata <= mem_r[rif.ridx];
    end else begin
      rif.rdata <= 8'h00;
    end
  end
endmodule

//--- logic/acr_serial_cfg.sv
/*
  Serial configuration register bank of a dual-channel converter: three-
  wire port with readback, pin and software reset, and decode of the
  reference, standby and power-state controls.
  Assumes asynchronous pins, sampled by the 250 MHz core clock.
*/
// Behaviour
// - writing one to bit 7 of address 00h clears all registers, self-clears.
// - readback disabled means the readback pin is driven low.
// - readback enabled means the readback pin carries register read data.
// - bit 2 of 20h selects low-rate operation at 80 MSPS or less.
// - reference field at 3Fh: 00 internal, 11 external.
// - bit 1 of 3Fh puts both channels in standby, buffers stay on.
// - power-state 0000 takes power-down from the three strap pins.
// - power-state 1000 is normal operation, overriding straps.
// - codes 1001/1010/1011 disable output buffers of B, A, both.
// - 1100 global power down, 1101 B standby, 1110 A standby.
// - 1111 interleaves both channels on A bus, CMOS interface only.
// - one write updates every field of that register together.
// - input bit captured on each shift-clock fall while select is low.
// - commit at each 16th fall, several words allowed, leftovers dropped.
// - word is eight address bits then eight data bits.
// - reset pin high over 10 ns clears registers; host then holds low.
`timescale 1ns/1ps
module acr_serial_cfg (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // serial port pins
  input wire logic sclk_pin,
  input wire logic port_select_n,
  input wire logic shift_in_pin,
  input wire logic reset_pin,
  output logic readback_out_pin,
  // strap pins
  input wire logic strap_pin_one,
  input wire logic strap_pin_two,
  input wire logic strap_pin_three,
  // converter controls
  output logic low_rate_mode,
  output logic ref_external,
  output logic conv_standby_a,
  output logic conv_standby_b,
  output logic global_power_down,
  output logic out_buf_off_a,
  output logic out_buf_off_b,
  output logic interleaved_output_mode
);
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} acr_phase_t;

  localparam int NPIN = 7;
  localparam int P_SCLK = 6;
  localparam int P_SEL = 5;
  localparam int P_SDI = 4;
  localparam int P_RST = 3;
  localparam logic [1:0] RST_LAST = 2'(acr_pkg::RST_PULSE_CYC - 1);

  acr_regs_if rif ();

  acr_reg_store u_store (
    .mclk (mclk),
    .rst_b (rst_b),
    .rif (rif.store)
  );

  // two-stage synchronisers for every pin
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  assign pin_raw = {sclk_pin, port_select_n, shift_in_pin, reset_pin,
                    strap_pin_one, strap_pin_two, strap_pin_three};

  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sync1_r[p] <= 1'b0;
        sync2_r[p] <= 1'b0;
      end else begin
        sync1_r[p] <= pin_raw[p];
        sync2_r[p] <= sync1_r[p];
      end
    end
  end

  logic sclk_d_r;
  logic sclk_fall;
  logic sel_low;
  logic sdi;
  logic rst_high;
  logic [2:0] straps;
  assign sel_low = !sync2_r[P_SEL];
  assign sdi = sync2_r[P_SDI];
  assign rst_high = sync2_r[P_RST];
  assign straps = sync2_r[2:0];
  assign sclk_fall = sclk_d_r && !sync2_r[P_SCLK];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sync2_r[P_SCLK];
    end
  end

  // control fields straight from the store
  logic readout_en;
  logic lvds_sel;
  logic [3:0] pstate;
  logic [1:0] ref_sel;
  logic stby_all;
  assign readout_en = rif.ctl[acr_pkg::IDX_RESET][acr_pkg::READOUT_BIT];
  assign lvds_sel = rif.ctl[acr_pkg::IDX_OUTIF][acr_pkg::OUTIF_LVDS_BIT];
  assign pstate = rif.ctl[acr_pkg::IDX_PSTATE][acr_pkg::PSTATE_HI:0];
  assign ref_sel = rif.ctl[acr_pkg::IDX_REFSTBY][acr_pkg::REF_HI:acr_pkg::REF_LO];
  assign stby_all = rif.ctl[acr_pkg::IDX_REFSTBY][acr_pkg::STBY_BIT];

  // serial word framing
  acr_phase_t phase_r;
  logic [3:0] bitcnt_r;
  logic [14:0] shift_r;
  logic shift_en;
  logic addr_done;
  logic word_done;
  logic [7:0] word_addr;
  logic [7:0] word_data;
  logic [7:0] rd_addr;
  logic [acr_pkg::IDXW-1:0] word_idx;
  logic word_hit;
  logic soft_commit;
  assign shift_en = sel_low && sclk_fall && phase_r != PH_IDLE;
  assign addr_done = shift_en && bitcnt_r == acr_pkg::ADDR_LAST;
  assign word_done = shift_en && bitcnt_r == acr_pkg::WORD_LAST;
  assign word_addr = shift_r[14:7];
  assign word_data = {shift_r[6:0], sdi};
  assign rd_addr = {shift_r[6:0], sdi};
  assign word_idx = acr_pkg::reg_index(word_addr);
  assign word_hit = word_idx != acr_pkg::IDXW'(acr_pkg::NREG);
  assign soft_commit = word_done && word_addr == acr_pkg::REG_OFS[0]
                       && word_data[acr_pkg::SRST_BIT];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PH_IDLE;
    end else if (!sel_low) begin
      phase_r <= PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE: phase_r <= PH_ADDR;
        PH_ADDR: if (addr_done) phase_r <= PH_DATA;
        PH_DATA: if (word_done) phase_r <= PH_ADDR;
      endcase
    end
  end

  // partial words are dropped when select rises
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitcnt_r <= 4'h0;
      shift_r <= 15'h0000;
    end else if (!sel_low) begin
      bitcnt_r <= 4'h0;
    end else if (shift_en) begin
      bitcnt_r <= bitcnt_r + 4'h1;
      shift_r <= {shift_r[13:0], sdi};
    end
  end

  // write commit and whole-bank clear
  logic [1:0] rcnt_r;
  logic pin_clear;
  assign pin_clear = rst_high && rcnt_r == RST_LAST;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_r <= 2'h0;
    end else if (!rst_high) begin
      rcnt_r <= 2'h0;
    end else if (rcnt_r != RST_LAST) begin
      rcnt_r <= rcnt_r + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rif.clr <= 1'b0;
    end else begin
      rif.clr <= soft_commit || pin_clear;
    end
  end

  // with readback on, only address 00h is writable; dummy data written there clears the readback enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rif.we <= 1'b0;
      rif.widx <= '0;
      rif.wdata <= 8'h00;
    end else begin
      rif.we <= word_done && word_hit && !soft_commit
                && (!readout_en || word_addr == acr_pkg::REG_OFS[0]);
      rif.widx <= word_idx;
      rif.wdata <= word_data;
    end
  end

  // readback path
  logic [1:0] rd_load_r;
  logic [7:0] out_shift_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rif.ridx <= acr_pkg::IDXW'(acr_pkg::NREG);
      rd_load_r <= 2'h0;
    end else begin
      if (addr_done) begin
        rif.ridx <= acr_pkg::reg_index(rd_addr);
      end
      // store read port answers one edge after the index lands
      rd_load_r <= {rd_load_r[0], addr_done};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_shift_r <= 8'h00;
    end else if (rd_load_r[1]) begin
      out_shift_r <= rif.rdata;
    end else if (shift_en && phase_r == PH_DATA) begin
      out_shift_r <= {out_shift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      readback_out_pin <= 1'b0;
    end else if (readout_en) begin
      readback_out_pin <= out_shift_r[7];
    end else begin
      readback_out_pin <= 1'b0;
    end
  end

  // converter control decode
  logic stby_a_nxt;
  logic stby_b_nxt;
  logic gpd_nxt;
  logic buf_a_nxt;
  logic buf_b_nxt;
  logic mux_nxt;

  always_comb begin
    stby_a_nxt = stby_all;
    stby_b_nxt = stby_all;
    gpd_nxt = 1'b0;
    buf_a_nxt = 1'b0;
    buf_b_nxt = 1'b0;
    mux_nxt = 1'b0;
    case (pstate)
      acr_pkg::PS_STRAP: begin
        case (straps)
          acr_pkg::ST_GLOBAL_PD: gpd_nxt = 1'b1;
          acr_pkg::ST_STBY_B: stby_b_nxt = 1'b1;
          acr_pkg::ST_STBY_A: stby_a_nxt = 1'b1;
          acr_pkg::ST_MUX: mux_nxt = !lvds_sel;
          default: gpd_nxt = 1'b0;
        endcase
      end
      acr_pkg::PS_NORMAL: gpd_nxt = 1'b0;
      acr_pkg::PS_BUF_B_OFF: buf_b_nxt = 1'b1;
      acr_pkg::PS_BUF_A_OFF: buf_a_nxt = 1'b1;
      acr_pkg::PS_BUF_AB_OFF: begin
        buf_a_nxt = 1'b1;
        buf_b_nxt = 1'b1;
      end
      acr_pkg::PS_GLOBAL_PD: gpd_nxt = 1'b1;
      acr_pkg::PS_STBY_B: stby_b_nxt = 1'b1;
      acr_pkg::PS_STBY_A: stby_a_nxt = 1'b1;
      acr_pkg::PS_MUX: mux_nxt = !lvds_sel;
      default: gpd_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_rate_mode <= 1'b0;
      ref_external <= 1'b0;
      conv_standby_a <= 1'b0;
      conv_standby_b <= 1'b0;
      global_power_down <= 1'b0;
      out_buf_off_a <= 1'b0;
      out_buf_off_b <= 1'b0;
      interleaved_output_mode <= 1'b0;
    end else begin
      low_rate_mode <=
        rif.ctl[acr_pkg::IDX_LOWRATE][acr_pkg::LOWRATE_BIT];
      ref_external <= ref_sel == acr_pkg::REF_EXT;
      conv_standby_a <= stby_a_nxt;
      conv_standby_b <= stby_b_nxt;
      global_power_down <= gpd_nxt;
      out_buf_off_a <= buf_a_nxt;
      out_buf_off_b <= buf_b_nxt;
      interleaved_output_mode <= mux_nxt;
    end
  end

  // checks
  readback_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !readout_en |=> !readback_out_pin)
    else $error("readback pin not low while readback disabled");

  readback_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
    readout_en |=> readback_out_pin == $past(out_shift_r[7]))
    else $error("readback pin does not follow read data");

  soft_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    soft_commit |=> rif.clr ##1 (rif.ctl == '0 && !rif.we))
    else $error("software reset did not clear the bank");

  word_commit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rif.we |-> $past(bitcnt_r) == acr_pkg::WORD_LAST
               && $past(shift_en))
    else $error("write committed off the sixteenth fall");

  addr_split_a: assert property (@(posedge mclk) disable iff (!rst_b)
    word_done && word_hit && !readout_en && !soft_commit
    |=> rif.we && rif.widx == $past(word_idx)
        && rif.wdata == $past(word_data))
    else $error("address and data split wrong");

  pin_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rst_high [*2] |=> rif.clr)
    else $error("reset pin pulse did not clear");

  standby_both_a: assert property (@(posedge mclk) disable iff (!rst_b)
    stby_all |=> conv_standby_a && conv_standby_b
                 && !out_buf_off_a && !out_buf_off_b)
    else $error("standby did not reach both channels");

  strap_pd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pstate == acr_pkg::PS_STRAP && straps == acr_pkg::ST_GLOBAL_PD
    |=> global_power_down)
    else $error("strap power down not followed");

  buf_both_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pstate == acr_pkg::PS_BUF_AB_OFF |=> out_buf_off_a && out_buf_off_b
                                         && !global_power_down)
    else $error("both buffers not disabled");

  mux_cmos_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pstate == acr_pkg::PS_MUX |=> interleaved_output_mode == !$past(lvds_sel))
    else $error("interleave not tied to cmos interface");
endmodule

//--- dv/acr_host_model.sv
/*
  Host controller model for the three-wire configuration port: shifts
  16-bit words, samples readback on shift-clock rises, pulses reset.
  Assumes the device captures data on shift-clock falls.
*/
`timescale 1ns/1ps
module acr_host_model (
  // serial port
  output logic sclk_pin,
  output logic port_select_n,
  output logic shift_in_pin,
  output logic reset_pin,
  // readback
  input wire logic readback_out_pin
);
  localparam realtime HALF = 62.5;

  // clock idles high, still between frames; reset pin held low
  initial begin
    sclk_pin = 1'b1;
    port_select_n = 1'b1;
    shift_in_pin = 1'b0;
    reset_pin = 1'b0;
  end

  task automatic open_frame();
    #1.3;
    port_select_n = 1'b0;
    #HALF;
  endtask

  // callers pass only zero fixed bits and reference codes 00 or 11
  task automatic shift_bits(input logic [15:0] w, input int n,
                            output logic [7:0] rd);
    rd = 8'h00;
    for (int i = 15; i > 15 - n; i--) begin
      if (i < 8) begin
        rd = {rd[6:0], readback_out_pin};
      end
      shift_in_pin = w[i];
      #HALF;
      sclk_pin = 1'b0;
      #HALF;
      sclk_pin = 1'b1;
    end
    // released data line no longer shows its last value
    shift_in_pin = ~shift_in_pin;
  endtask

  task automatic close_frame();
    #HALF;
    port_select_n = 1'b1;
    #HALF;
  endtask

  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    open_frame();
    shift_bits({a, d}, 16, rd);
    close_frame();
  endtask

  task automatic pulse_reset();
    reset_pin = 1'b1;
    #11;
    reset_pin = 1'b0;
  endtask
endmodule

//--- dv/acr_serial_cfg_tb.sv
/*
  Self-checking bench for the serial configuration register bank.
  Assumes the host model above drives the serial port and reset pin.
*/
`timescale 1ns/1ps
module acr_serial_cfg_tb;
  logic mclk, rst_b;
  logic [2:0] strap;
  wire sclk_w, sel_n_w, sdi_w, rpin_w;
  logic readback_out_pin, low_rate_mode, ref_external;
  logic conv_standby_a, conv_standby_b, global_power_down;
  logic out_buf_off_a, out_buf_off_b, interleaved_output_mode;
  logic [7:0] ctl_v, rd;
  int err_total, n_checks;
  logic [7:0] st_exp [4] = '{8'h10, 8'h04, 8'h08, 8'h20};
  logic [7:0] ps_exp [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                             8'h10, 8'h04, 8'h08, 8'h20};

  assign ctl_v = {2'h0, interleaved_output_mode, global_power_down,
                  conv_standby_a, conv_standby_b, out_buf_off_a,
                  out_buf_off_b};

  acr_serial_cfg u_dut (
    .mclk(mclk), .rst_b(rst_b), .sclk_pin(sclk_w),
    .port_select_n(sel_n_w), .shift_in_pin(sdi_w), .reset_pin(rpin_w),
    .readback_out_pin(readback_out_pin), .strap_pin_one(strap[2]),
    .strap_pin_two(strap[1]), .strap_pin_three(strap[0]),
    .low_rate_mode(low_rate_mode), .ref_external(ref_external),
    .conv_standby_a(conv_standby_a), .conv_standby_b(conv_standby_b),
    .global_power_down(global_power_down), .out_buf_off_a(out_buf_off_a),
    .out_buf_off_b(out_buf_off_b),
    .interleaved_output_mode(interleaved_output_mode));

  acr_host_model u_host (
    .sclk_pin(sclk_w), .port_select_n(sel_n_w), .shift_in_pin(sdi_w),
    .reset_pin(rpin_w), .readback_out_pin(readback_out_pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(a, d, rd);
    repeat (10) @(negedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host.xfer(a, 8'h00, rd);
    chk("readback byte", exp, rd);
    repeat (10) @(negedge mclk);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // guards against a hang anywhere in the sequence
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    end_sim();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    rst_b = 1'b0;
    strap = 3'h0;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    chk("controls after reset", 8'h00, ctl_v);
    chk("readback pin idle", 8'h00, {7'h0, readback_out_pin});
    // strap pins steer power-down while the power-state code is zero
    for (int s = 4; s < 8; s++) begin
      strap = 3'(s);
      repeat (8) @(negedge mclk);
      chk("strap controls", st_exp[s-4], ctl_v);
    end
    // each code 1000 to 1111 overrides straps held at 111
    for (int c = 8; c < 16; c++) begin
      wr(8'h40, 8'(c));
      chk("power-state controls", ps_exp[c-8], ctl_v);
    end
    // an LVDS interface keeps interleave off
    wr(8'h41, 8'h80);
    chk("interleave on lvds", 8'h00, ctl_v);
    wr(8'h41, 8'h00);
    wr(8'h40, 8'h08);
    wr(8'h20, 8'h04);
    wr(8'h3F, 8'h62);
    chk("ref and rate", 8'h03, {6'h0, ref_external, low_rate_mode});
    chk("standby both", 8'h0C, ctl_v);
    wr(8'h3F, 8'h00);
    chk("ref internal", 8'h01, {6'h0, ref_external, low_rate_mode});
    chk("standby off", 8'h00, ctl_v);
    // two words in one frame plus a leftover partial word
    u_host.open_frame();
    u_host.shift_bits({8'h20, 8'h00}, 16, rd);
    u_host.shift_bits({8'h40, 8'h0C}, 16, rd);
    u_host.shift_bits({8'h20, 8'h04}, 12, rd);
    u_host.close_frame();
    repeat (10) @(negedge mclk);
    chk("rate after burst", 8'h00, {7'h0, low_rate_mode});
    chk("power after burst", 8'h10, ctl_v);
    // readback of stored bytes and of unmapped address 01h
    wr(8'h00, 8'h01);
    rd_chk(8'h40, 8'h0C);
    rd_chk(8'h20, 8'h00);
    chk("power while readback", 8'h10, ctl_v);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    chk("readback pin off", 8'h00, {7'h0, readback_out_pin});
    // software reset clears everything and clears itself
    wr(8'h20, 8'h04);
    wr(8'h00, 8'h80);
    chk("rate after soft reset", 8'h00, {7'h0, low_rate_mode});
    chk("controls after soft reset", 8'h20, ctl_v);
    wr(8'h00, 8'h01);
    rd_chk(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    // pin reset
    wr(8'h20, 8'h04);
    chk("rate set", 8'h01, {7'h0, low_rate_mode});
    u_host.pulse_reset();
    repeat (10) @(negedge mclk);
    chk("rate after pin reset", 8'h00, {7'h0, low_rate_mode});
    end_sim();
  end
endmodule
